// [bench/smbus_event_src.sv]
// Purpose: far-side model: management bus events and eeprom default autoload
// Assumes: requests from the bench are one-cycle pulses on ref_clk_i
// Notes: default value lines carry junk (inverted) outside a load strobe
`timescale 1ns/1ps

module smbus_event_src #(
    parameter logic [15:0] LOAD_LINK_CFG = 16'h1234,
    parameter logic        LOAD_PWR_DIS  = 1'b1
) (
    input  wire logic        ref_clk_i,
    input  wire logic        pec_req_i,
    input  wire logic        unsup_req_i,
    input  wire logic        load_req_i,
    output logic             pec_fail_o,
    output logic             unsup_cmd_o,
    output logic             dflt_load_o,
    output logic      [15:0] dflt_link_cfg_o,
    output logic             dflt_pwr_dis_o
);
    // event pulses launched just after the edge, one cycle wide
    always_ff @(posedge ref_clk_i) begin
        pec_fail_o  <= pec_req_i;
        unsup_cmd_o <= unsup_req_i;
        dflt_load_o <= load_req_i;
    end

    // values only valid with the strobe, so a design that samples late sees junk
    always_ff @(posedge ref_clk_i) begin
        dflt_link_cfg_o <= load_req_i ? LOAD_LINK_CFG : ~LOAD_LINK_CFG;
        dflt_pwr_dis_o  <= load_req_i ? LOAD_PWR_DIS : ~LOAD_PWR_DIS;
    end
endmodule // smbus_event_src

// [bench/switch_vendor_control_regs_tb_top.sv]
// Purpose: self-checking bench for the vendor control register bank
// Assumes: strap pins at 3'h5 (address 7'h6d), moved to 3'h2 for the second reset
// Notes: table of plain accesses first, then outputs, events and reset by hand
`timescale 1ns/1ps

module switch_vendor_control_regs_tb_top;
    import switch_vendor_control_pkg::*;
    typedef struct {logic wr; logic [11:0] a; logic [31:0] d; logic [3:0] be;} row_t;
    logic          ref_clk_i = 1'b0;
    logic          srst_i = 1'b1;
    logic          cfg_wr_i = 1'b0, cfg_rd_i = 1'b0;
    logic [11:0]   cfg_addr_i = 12'h000;
    logic [31:0]   cfg_wdata_i = 32'h0, cfg_rdata_o;
    logic [3:0]    cfg_be_i = 4'h0;
    logic [2:0]    strap = 3'h5;
    logic          cfg_rvalid_o, pec_fail_i, unsup_cmd_i, dflt_load_i, dflt_pwr_dis_i;
    logic [15:0]   dflt_link_cfg_i;
    logic          pec_req = 1'b0, unsup_req = 1'b0, load_req = 1'b0;
    link_width_t   port_width_i [5] = '{default: 2'h0};
    logic [9:0]    width_flat;
    logic          smbus_mode_o, pec_check_en_o, power_save_en_o, led_en_o, led_mode_o;
    logic [6:0]    smbus_addr_o;
    logic [4:0]    flow_en_o, led_sel_o;
    logic [79:0]   port_threshold_o;
    int            err_total = 0, compares = 0;
    // read rows carry the expected word in d
    row_t rows [19] = '{
        '{0, 12'h340, 32'h00040000, 4'hf}, '{0, 12'h354, 32'h02000080, 4'hf},
        '{0, 12'h358, 32'h00000800, 4'hf}, '{0, 12'h350, 32'h00000000, 4'hf},
        '{0, 12'h360, 32'h00000000, 4'hf}, '{0, 12'h364, 32'h00000000, 4'hf},
        '{0, 12'h344, 32'h000002db, 4'hf},
        '{1, 12'h350, 32'hffffffff, 4'hf}, '{0, 12'h350, 32'h0000003e, 4'hf},
        '{1, 12'h354, 32'h12345678, 4'h3}, '{0, 12'h354, 32'h02005678, 4'hf},
        '{1, 12'h358, 32'hffffffff, 4'hf}, '{0, 12'h358, 32'h0000ffff, 4'hf},
        '{1, 12'h364, 32'hffffffff, 4'hf}, '{0, 12'h364, 32'h0000007f, 4'hf},
        '{1, 12'h360, 32'hffffffff, 4'hf}, '{0, 12'h360, 32'h00000001, 4'hf},
        '{1, 12'h340, 32'hffffffff, 4'hf}, '{0, 12'h340, 32'h00040000, 4'hf}};

    assign width_flat = {port_width_i[4], port_width_i[3], port_width_i[2],
                         port_width_i[1], port_width_i[0]};

    always #50 ref_clk_i = ~ref_clk_i;

    switch_vendor_control_regs switch_vendor_control_regs_inst (
        .ref_clk_i(ref_clk_i), .srst_i(srst_i), .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i),
        .cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i), .cfg_be_i(cfg_be_i),
        .cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o), .strap_addr_i(strap),
        .pec_fail_i(pec_fail_i), .unsup_cmd_i(unsup_cmd_i), .dflt_load_i(dflt_load_i),
        .dflt_link_cfg_i(dflt_link_cfg_i), .dflt_pwr_dis_i(dflt_pwr_dis_i),
        .port_width_i(width_flat), .smbus_mode_o(smbus_mode_o), .smbus_addr_o(smbus_addr_o),
        .pec_check_en_o(pec_check_en_o), .flow_en_o(flow_en_o),
        .port_threshold_o(port_threshold_o), .power_save_en_o(power_save_en_o),
        .led_sel_o(led_sel_o), .led_en_o(led_en_o), .led_mode_o(led_mode_o));

    smbus_event_src smbus_event_src_inst (
        .ref_clk_i(ref_clk_i), .pec_req_i(pec_req), .unsup_req_i(unsup_req),
        .load_req_i(load_req), .pec_fail_o(pec_fail_i), .unsup_cmd_o(unsup_cmd_i),
        .dflt_load_o(dflt_load_i), .dflt_link_cfg_o(dflt_link_cfg_i),
        .dflt_pwr_dis_o(dflt_pwr_dis_i));

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t word got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_vec(input logic [79:0] got, input logic [79:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t outputs got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic bus_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge ref_clk_i);
        cfg_wr_i    <= 1'b1;
        cfg_addr_i  <= a;
        cfg_wdata_i <= d;
        cfg_be_i    <= be;
        @(posedge ref_clk_i);
        cfg_wr_i <= 1'b0;
    endtask

    // answer comes exactly one cycle after the taken edge
    task automatic bus_rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge ref_clk_i);
        cfg_rd_i   <= 1'b1;
        cfg_addr_i <= a;
        @(posedge ref_clk_i);
        cfg_rd_i <= 1'b0;
        #1;
        chk_word({31'h0, cfg_rvalid_o}, 32'h1);
        d = cfg_rdata_o;
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] v;
        bus_rd(a, v);
        chk_word(v, exp);
    endtask

    // one-cycle request to the far-side model, then let the pulse land
    // sel: 0 packet error, 1 unsupported command, other default load
    task automatic fire(input int sel);
        @(posedge ref_clk_i);
        case (sel)
            0: pec_req <= 1'b1;
            1: unsup_req <= 1'b1;
            default: load_req <= 1'b1;
        endcase
        @(posedge ref_clk_i);
        {pec_req, unsup_req, load_req} <= 3'b000;
        repeat (3) @(posedge ref_clk_i);
    endtask

    task automatic summarize();
        $display("counts: compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // hang guard: bounded run length
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        err_total++;
        $display("ERROR t=%0t run did not finish", $time);
        summarize();
    end

    initial begin
        repeat (10) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        for (int i = 0; i < 19; i++) begin
            if (rows[i].wr)
                bus_wr(rows[i].a, rows[i].d, rows[i].be);
            else
                rd_chk(rows[i].a, rows[i].d);
        end
        rd_chk(12'h348, 32'h0);
        $display("test table done");
        repeat (2) @(posedge ref_clk_i);
        chk_vec({flow_en_o, led_mode_o, led_en_o, led_sel_o, power_save_en_o},
                {5'h1f, 1'b1, 1'b1, 5'h1f, 1'b0});
        // widths x1,x2,x4,code3,x1 for ports 1..5
        port_width_i <= '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
        repeat (3) @(posedge ref_clk_i);
        chk_vec(port_threshold_o, {16'h5678, 16'hffff, 16'hffff, 16'h0200, 16'h5678});
        bus_wr(12'h350, 32'h0000003a, 4'hf);
        repeat (3) @(posedge ref_clk_i);
        chk_vec(port_threshold_o, {16'h5678, 16'hffff, 16'hffff, 16'h0000, 16'h5678});
        $display("test thresholds done");
        bus_wr(12'h344, 32'h00000054, 4'h3);
        repeat (3) @(posedge ref_clk_i);
        chk_vec({smbus_mode_o, smbus_addr_o, pec_check_en_o}, {1'b0, 7'h2a, 1'b1});
        fire(0);
        rd_chk(12'h344, 32'h20000054);
        bus_wr(12'h344, 32'h00000000, 4'h8);
        rd_chk(12'h344, 32'h20000054);
        fire(1);
        rd_chk(12'h344, 32'h60000054);
        bus_wr(12'h344, 32'h20000000, 4'h8);
        rd_chk(12'h344, 32'h40000054);
        bus_wr(12'h344, 32'h40000000, 4'h8);
        rd_chk(12'h344, 32'h00000054);
        $display("test sideband events done");
        // second reset mid-run; outputs fall back while held, straps move
        @(posedge ref_clk_i);
        srst_i <= 1'b1;
        strap  <= 3'h2;
        repeat (10) @(posedge ref_clk_i);
        chk_vec({smbus_mode_o, smbus_addr_o, pec_check_en_o, power_save_en_o, flow_en_o,
                 led_sel_o, led_en_o, led_mode_o, cfg_rvalid_o, port_threshold_o[15:0]},
                {1'b1, 7'h68, 1'b0, 1'b1, 5'h00, 5'h00, 1'b0, 1'b0, 1'b0,
                 16'h0000});
        srst_i <= 1'b0;
        repeat (6) @(posedge ref_clk_i);
        fire(0);
        rd_chk(12'h344, 32'h000002d5);
        fire(2);
        rd_chk(12'h340, 32'h12340000);
        chk_vec({79'h0, power_save_en_o}, 80'h0);
        $display("test reset and autoload done");
        summarize();
    end
endmodule // switch_vendor_control_regs_tb_top

// [src/switch_vendor_control_defs.svh]
// Purpose: constants for the vendor control register bank
// Assumes: 32-bit word registers at byte offsets in the upstream port space
// Notes: field positions, offsets and reset values live here as macros
// Notes on behaviour
// - bit 0 of sideband control selects two-wire (0) or smbus (1); resets to 1.
// - smbus address in bits 7:1, upper four bits reset to 1101b.
// - lower three address bits loaded from strap pins at reset; writable after.
// - packet error check runs only while bit 9 is 0; bit 9 resets to 1.
// - status bit 29 set on failed error check; write one clears; resets 0.
// - status bit 30 set on unsupported smbus command; write one clears; resets 0.
// - sideband control register exists only in upstream port register space.
// - per-port completion flow enables at bits 1 to 5, reset disabled.
// - single-lane threshold in bits 15:0, resets to 0080h.
// - two-lane threshold in bits 31:16 of same register, resets to 0200h.
// - four-lane threshold bits 15:0 of separate register, resets 0800h; upper reserved.
// - power saving off while bit 0 set; resets 0; default loadable externally.
// - read-only link-layer config field bits 31:16, resets 0004h, default loadable.
// - led control: mode select 4:0, enable bit 5, mode bit 6; all reset zero.
`ifndef SWITCH_VENDOR_CONTROL_DEFS_SVH
`define SWITCH_VENDOR_CONTROL_DEFS_SVH

`define OFF_LINK_CFG     12'h340
`define OFF_SIDEBAND     12'h344
`define OFF_FLOW_EN      12'h350
`define OFF_THR_NARROW   12'h354
`define OFF_THR_WIDE     12'h358
`define OFF_PWR_SAVE     12'h360
`define OFF_LED          12'h364

`define SB_SEL_BIT       0
`define SB_ADDR_HI       7
`define SB_ADDR_LO       1
`define SB_STRAP_HI      3
`define SB_ADDR_TOP_RST  4'hd
`define SB_SEL_RST       1'b1
`define SB_PEC_DIS_BIT   9
`define SB_PEC_DIS_RST   1'b1
`define SB_PEC_FAIL_BIT  29
`define SB_UNSUP_BIT     30

`define LINK_CFG_RST     16'h0004
`define THR_X1_RST       16'h0080
`define THR_X2_RST       16'h0200
`define THR_X4_RST       16'h0800
`define FLOW_EN_LO       1
`define LED_EN_BIT       5
`define LED_MODE_BIT     6
`define LED_SEL_W        5
`define PWR_DIS_BIT      0

`define WIDTH_X1         2'h0
`define WIDTH_X2         2'h1
`define WIDTH_X4         2'h2

`endif

// [src/switch_vendor_control_pkg.sv]
// Purpose: types for the vendor control register bank
// Assumes: constants come from the defs header
// Notes: link width code as carried per port
package switch_vendor_control_pkg;
    typedef logic [1:0]  link_width_t;
    typedef logic [15:0] threshold_t;
endpackage

// [src/switch_vendor_control_regs.sv]
// Purpose: upstream-port vendor control and status register bank
// Assumes: one config access per cycle; events are one-cycle pulses on ref_clk_i
// Notes: external default loads take effect on a load strobe, not via config writes
`timescale 1ns/1ps
`include "switch_vendor_control_defs.svh"

module switch_vendor_control_regs #(
    parameter int NUM_PORTS   = 5,
    parameter bit IS_UPSTREAM = 1'b1
) (
    input  wire logic                                  ref_clk_i,
    input  wire logic                                  srst_i,
    input  wire logic                                  cfg_wr_i,
    input  wire logic                                  cfg_rd_i,
    input  wire logic [11:0]                           cfg_addr_i,
    input  wire logic [31:0]                           cfg_wdata_i,
    input  wire logic [3:0]                            cfg_be_i,
    output logic      [31:0]                           cfg_rdata_o,
    output logic                                       cfg_rvalid_o,
    input  wire logic [2:0]                            strap_addr_i,
    input  wire logic                                  pec_fail_i,
    input  wire logic                                  unsup_cmd_i,
    input  wire logic                                  dflt_load_i,
    input  wire logic [15:0]                           dflt_link_cfg_i,
    input  wire logic                                  dflt_pwr_dis_i,
    input  wire logic [NUM_PORTS*2-1:0]                port_width_i,
    output logic                                       smbus_mode_o,
    output logic      [6:0]                            smbus_addr_o,
    output logic                                       pec_check_en_o,
    output logic      [NUM_PORTS-1:0]                  flow_en_o,
    output logic      [NUM_PORTS*16-1:0]               port_threshold_o,
    output logic                                       power_save_en_o,
    output logic      [4:0]                            led_sel_o,
    output logic                                       led_en_o,
    output logic                                       led_mode_o
);
    import switch_vendor_control_pkg::*;

    // elaboration check: the enable field holds at most five ports
    // a wider switch would need a second enable word
    if (NUM_PORTS < 1 || NUM_PORTS > 5) begin : g_bad_ports
        $error("NUM_PORTS must be 1 to 5");
    end

    logic [2:0]       strap_s1;
    logic [2:0]       strap_s2;
    logic [2:0]       strap_s3;
    logic             strap_pend;
    logic             sb_sel_reg;
    logic [6:0]       sb_addr_reg;
    logic             pec_dis_reg;
    logic             pec_fail_reg;
    logic             unsup_reg;
    logic [15:0]      link_cfg_reg;
    logic [NUM_PORTS-1:0] flow_en_reg;
    threshold_t       thr_x1_reg;
    threshold_t       thr_x2_reg;
    threshold_t       thr_x4_reg;
    logic             pwr_dis_reg;
    logic [4:0]       led_sel_reg;
    logic             led_en_reg;
    logic             led_mode_reg;
    logic [31:0]      rdata_next;
    logic [31:0]      wmask;

    // byte enables widened to a bit mask
    assign wmask = {{8{cfg_be_i[3]}}, {8{cfg_be_i[2]}}, {8{cfg_be_i[1]}}, {8{cfg_be_i[0]}}};

    logic wr_link;
    logic wr_sb;
    logic wr_flow;
    logic wr_thn;
    logic wr_thw;
    logic wr_pwr;
    logic wr_led;
    // sideband register decodes only in the upstream instance
    assign wr_link = cfg_wr_i && (cfg_addr_i == `OFF_LINK_CFG);
    assign wr_sb   = cfg_wr_i && IS_UPSTREAM && (cfg_addr_i == `OFF_SIDEBAND);
    assign wr_flow = cfg_wr_i && (cfg_addr_i == `OFF_FLOW_EN);
    assign wr_thn  = cfg_wr_i && (cfg_addr_i == `OFF_THR_NARROW);
    assign wr_thw  = cfg_wr_i && (cfg_addr_i == `OFF_THR_WIDE);
    assign wr_pwr  = cfg_wr_i && (cfg_addr_i == `OFF_PWR_SAVE);
    assign wr_led  = cfg_wr_i && (cfg_addr_i == `OFF_LED);

    // strap pins are asynchronous: three stages, settle when last two agree
    // stages carry no reset: they only follow the pins
    always_ff @(posedge ref_clk_i) begin
        strap_s1 <= strap_addr_i;
        strap_s2 <= strap_s1;
        strap_s3 <= strap_s2;
    end

    // sideband control: select, address, check disable
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            sb_sel_reg  <= `SB_SEL_RST;
            sb_addr_reg <= {`SB_ADDR_TOP_RST, 3'h0};
            pec_dis_reg <= `SB_PEC_DIS_RST;
            strap_pend  <= 1'b1;
        end else begin
            // strap captured after release, once the synchroniser settles
            if (strap_pend && (strap_s2 == strap_s3)) begin
                sb_addr_reg[2:0] <= strap_s3;
                strap_pend       <= 1'b0;
            end
            if (wr_sb && cfg_be_i[0]) begin
                sb_sel_reg  <= cfg_wdata_i[`SB_SEL_BIT];
                sb_addr_reg <= cfg_wdata_i[`SB_ADDR_HI:`SB_ADDR_LO];
                strap_pend  <= 1'b0;
            end
            if (wr_sb && cfg_be_i[1]) begin
                pec_dis_reg <= cfg_wdata_i[`SB_PEC_DIS_BIT];
            end
        end
    end

    // sticky error flags: a new event wins over a clear in the same cycle
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            pec_fail_reg <= 1'b0;
            unsup_reg    <= 1'b0;
        end else begin
            if (pec_fail_i && !pec_dis_reg) begin
                pec_fail_reg <= 1'b1;
            end else if (wr_sb && cfg_be_i[3] && cfg_wdata_i[`SB_PEC_FAIL_BIT]) begin
                pec_fail_reg <= 1'b0;
            end
            if (unsup_cmd_i) begin
                unsup_reg <= 1'b1;
            end else if (wr_sb && cfg_be_i[3] && cfg_wdata_i[`SB_UNSUP_BIT]) begin
                unsup_reg <= 1'b0;
            end
        end
    end

    // link-layer config: read-only to config writes, default loadable
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            link_cfg_reg <= `LINK_CFG_RST;
        end else if (dflt_load_i) begin
            link_cfg_reg <= dflt_link_cfg_i;
        end
    end

    // flow-control enables and thresholds
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            flow_en_reg <= '0;
            thr_x1_reg  <= `THR_X1_RST;
            thr_x2_reg  <= `THR_X2_RST;
            thr_x4_reg  <= `THR_X4_RST;
        end else begin
            if (wr_flow) begin
                flow_en_reg <= (flow_en_reg & ~wmask[`FLOW_EN_LO +: NUM_PORTS])
                             | (cfg_wdata_i[`FLOW_EN_LO +: NUM_PORTS]
                                & wmask[`FLOW_EN_LO +: NUM_PORTS]);
            end
            if (wr_thn) begin
                thr_x1_reg <= (thr_x1_reg & ~wmask[15:0]) | (cfg_wdata_i[15:0] & wmask[15:0]);
                thr_x2_reg <= (thr_x2_reg & ~wmask[31:16])
                            | (cfg_wdata_i[31:16] & wmask[31:16]);
            end
            if (wr_thw) begin
                thr_x4_reg <= (thr_x4_reg & ~wmask[15:0]) | (cfg_wdata_i[15:0] & wmask[15:0]);
            end
        end
    end

    // power saving disable: config write or external default load
    // a default load outranks a config write landing in the same cycle
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            pwr_dis_reg <= 1'b0;
        end else if (dflt_load_i) begin
            pwr_dis_reg <= dflt_pwr_dis_i;
        end else if (wr_pwr && cfg_be_i[0]) begin
            pwr_dis_reg <= cfg_wdata_i[`PWR_DIS_BIT];
        end
    end

    // led display control
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            led_sel_reg  <= '0;
            led_en_reg   <= 1'b0;
            led_mode_reg <= 1'b0;
        end else if (wr_led && cfg_be_i[0]) begin
            led_sel_reg  <= cfg_wdata_i[`LED_SEL_W-1:0];
            led_en_reg   <= cfg_wdata_i[`LED_EN_BIT];
            led_mode_reg <= cfg_wdata_i[`LED_MODE_BIT];
        end
    end

    // read mux; reserved and unmapped bits read zero
    always_comb begin
        rdata_next = 32'h0;
        case (cfg_addr_i)
            `OFF_LINK_CFG: rdata_next[31:16] = link_cfg_reg;
            `OFF_SIDEBAND: begin
                if (IS_UPSTREAM) begin
                    rdata_next[`SB_SEL_BIT]                = sb_sel_reg;
                    rdata_next[`SB_ADDR_HI:`SB_ADDR_LO]   = sb_addr_reg;
                    rdata_next[`SB_PEC_DIS_BIT]            = pec_dis_reg;
                    rdata_next[`SB_PEC_FAIL_BIT]           = pec_fail_reg;
                    rdata_next[`SB_UNSUP_BIT]              = unsup_reg;
                end
            end
            `OFF_FLOW_EN:    rdata_next[`FLOW_EN_LO +: NUM_PORTS] = flow_en_reg;
            `OFF_THR_NARROW: rdata_next = {thr_x2_reg, thr_x1_reg};
            `OFF_THR_WIDE:   rdata_next[15:0] = thr_x4_reg;
            `OFF_PWR_SAVE:   rdata_next[`PWR_DIS_BIT] = pwr_dis_reg;
            `OFF_LED:        rdata_next[`LED_MODE_BIT:0] = {led_mode_reg, led_en_reg, led_sel_reg};
            default:         rdata_next = 32'h0;
        endcase
    end

    // registered read answer, one cycle after the request
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            cfg_rdata_o  <= 32'h0;
            cfg_rvalid_o <= 1'b0;
        end else begin
            cfg_rvalid_o <= cfg_rd_i;
            cfg_rdata_o  <= cfg_rd_i ? rdata_next : 32'h0;
        end
    end

    // a disabled port shows zero so the consumer never sees a stale threshold
    // per-port threshold chosen by negotiated width; unknown widths use x4
    genvar gp;
    generate
        for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
            link_width_t w;
            assign w = port_width_i[gp*2 +: 2];
            always_ff @(posedge ref_clk_i) begin
                if (srst_i) begin
                    port_threshold_o[gp*16 +: 16] <= 16'h0;
                end else if (!flow_en_reg[gp]) begin
                    port_threshold_o[gp*16 +: 16] <= 16'h0;
                end else if (w == `WIDTH_X1) begin
                    port_threshold_o[gp*16 +: 16] <= thr_x1_reg;
                end else if (w == `WIDTH_X2) begin
                    port_threshold_o[gp*16 +: 16] <= thr_x2_reg;
                end else begin
                    port_threshold_o[gp*16 +: 16] <= thr_x4_reg;
                end
            end
        end
    endgenerate

    // control outputs registered from the bank
    // pec check and power save enables are the inverse of the stored disable bits
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            smbus_mode_o    <= `SB_SEL_RST;
            smbus_addr_o    <= {`SB_ADDR_TOP_RST, 3'h0};
            pec_check_en_o  <= 1'b0;
            flow_en_o       <= '0;
            power_save_en_o <= 1'b1;
            led_sel_o       <= '0;
            led_en_o        <= 1'b0;
            led_mode_o      <= 1'b0;
        end else begin
            smbus_mode_o    <= sb_sel_reg;
            smbus_addr_o    <= sb_addr_reg;
            pec_check_en_o  <= !pec_dis_reg;
            flow_en_o       <= flow_en_reg;
            power_save_en_o <= !pwr_dis_reg;
            led_sel_o       <= led_sel_reg;
            led_en_o        <= led_en_reg;
            led_mode_o      <= led_mode_reg;
        end
    end

    // error flags: set, keep and clear
    a_pec_sticky: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (pec_fail_i && !pec_dis_reg) |=> pec_fail_reg) else $error("pec flag not set");
    a_unsup_sticky: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        unsup_cmd_i |=> unsup_reg) else $error("unsupported flag not set");
    a_w1c_zero_keeps: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (unsup_reg && !(wr_sb && cfg_be_i[3] && cfg_wdata_i[`SB_UNSUP_BIT]))
        |=> unsup_reg) else $error("unsupported flag lost");
    a_pec_clear: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (wr_sb && cfg_be_i[3] && cfg_wdata_i[`SB_PEC_FAIL_BIT] && !pec_fail_i)
        |=> !pec_fail_reg) else $error("pec flag not cleared");
    a_unsup_clear: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (wr_sb && cfg_be_i[3] && cfg_wdata_i[`SB_UNSUP_BIT] && !unsup_cmd_i)
        |=> !unsup_reg) else $error("unsupported flag not cleared");
    a_pec_gate: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (!pec_fail_reg && !wr_sb && pec_dis_reg) |=> !pec_fail_reg)
        else $error("pec flag set while check disabled");

    // sideband fields after reset and on writes
    a_sb_rst: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        $fell(srst_i) |-> (sb_sel_reg == `SB_SEL_RST && pec_dis_reg == `SB_PEC_DIS_RST
        && sb_addr_reg[6:3] == `SB_ADDR_TOP_RST)) else $error("sideband reset value wrong");
    a_strap_load: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (strap_pend && strap_s2 == strap_s3 && !(wr_sb && cfg_be_i[0]))
        |=> (sb_addr_reg[2:0] == $past(strap_s3))) else $error("strap bits not loaded");
    a_sel_write: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (wr_sb && cfg_be_i[0]) |=> (sb_sel_reg == $past(cfg_wdata_i[`SB_SEL_BIT])))
        else $error("select bit not written");
    a_mode_out: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        1'b1 |=> (smbus_mode_o == $past(sb_sel_reg))) else $error("mode output stale");

    // bus answers, read-only field and default loads
    a_rsvd_zero: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (cfg_rd_i && cfg_addr_i == `OFF_THR_WIDE) |=> (cfg_rdata_o[31:16] == 16'h0))
        else $error("reserved bits nonzero");
    a_unmapped_zero: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (cfg_rd_i && !(cfg_addr_i inside {`OFF_LINK_CFG, `OFF_SIDEBAND, `OFF_FLOW_EN,
        `OFF_THR_NARROW, `OFF_THR_WIDE, `OFF_PWR_SAVE, `OFF_LED})) |=> (cfg_rdata_o == 32'h0))
        else $error("unmapped word not zero");
    a_rd_latency: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        cfg_rd_i |=> cfg_rvalid_o) else $error("read answer missing");
    a_link_ro: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (wr_link && !dflt_load_i) |=> $stable(link_cfg_reg))
        else $error("read-only field written");
    a_dflt_load: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        dflt_load_i |=> (link_cfg_reg == $past(dflt_link_cfg_i)
        && pwr_dis_reg == $past(dflt_pwr_dis_i))) else $error("default load missed");
    a_pwr_follow: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (wr_pwr && cfg_be_i[0] && !dflt_load_i) ##1 !dflt_load_i
        |=> (power_save_en_o == !$past(cfg_wdata_i[`PWR_DIS_BIT], 2)))
        else $error("power save output wrong");
    a_led_write: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (wr_led && cfg_be_i[0]) |=> (led_sel_reg == $past(cfg_wdata_i[`LED_SEL_W-1:0])))
        else $error("led select not written");

    // per-port threshold selection, watched on port 1
    a_thr_select: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        !flow_en_reg[0] |=> (port_threshold_o[15:0] == 16'h0))
        else $error("threshold on disabled port");
    a_thr_x1: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (flow_en_reg[0] && port_width_i[1:0] == `WIDTH_X1)
        |=> (port_threshold_o[15:0] == $past(thr_x1_reg))) else $error("x1 threshold wrong");
    a_thr_x2: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (flow_en_reg[0] && port_width_i[1:0] == `WIDTH_X2)
        |=> (port_threshold_o[15:0] == $past(thr_x2_reg))) else $error("x2 threshold wrong");
    a_thr_x4: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (flow_en_reg[0] && port_width_i[1:0] != `WIDTH_X1
        && port_width_i[1:0] != `WIDTH_X2)
        |=> (port_threshold_o[15:0] == $past(thr_x4_reg))) else $error("x4 threshold wrong");

endmodule // switch_vendor_control_regs
